/* rtl/conv_regs_pkg.sv */
package conv_regs_pkg;

   // register indices; byte address is four times the index
   localparam logic [8:0] IDX_SREF_CTRL  = 9'h03a;
   localparam logic [8:0] IDX_FRM_OFS    = 9'h08c;
   localparam logic [8:0] IDX_DIV_RATIO  = 9'h0f8;
   localparam logic [8:0] IDX_RSVD_F9    = 9'h0f9;
   localparam logic [8:0] IDX_XFER       = 9'h0ff;
   localparam logic [8:0] IDX_IRQ_STAT   = 9'h100;
   localparam logic [8:0] IDX_IRQ_MASK   = 9'h101;
   localparam logic [8:0] IDX_DIG_CTRL   = 9'h105;
   localparam logic [8:0] IDX_CAL_CTRL   = 9'h10a;
   localparam logic [8:0] IDX_CAL_THR_A  = 9'h10d;
   localparam logic [8:0] IDX_CAL_THR_B  = 9'h10e;

   // reset values
   localparam logic [7:0] RST_ZERO       = 8'h00;
   localparam logic [7:0] RST_CAL_CTRL   = 8'h10;
   localparam logic [7:0] RST_CAL_THR_A  = 8'h3d;
   localparam logic [7:0] RST_CAL_THR_B  = 8'h14;
   localparam logic [7:0] RST_IRQ_MASK   = 8'h30;

   // field positions
   localparam int BIT_XFER      = 0;
   localparam int BIT_RATIO     = 0;
   localparam int BIT_SREF_CLR  = 6;
   localparam int BIT_CAL_EN    = 4;
   localparam int BIT_PLL       = 7;
   localparam int BIT_HOLD      = 3;
   localparam int BIT_SETUP     = 2;
   localparam int BIT_CLKERR    = 0;

   // implemented status bits and writable mask bits
   localparam logic [7:0] STAT_BITS      = 8'h8d;
   localparam logic [7:0] MASK_BITS      = 8'hbd;
   localparam logic [4:0] DIG_CTRL_BITS  = 5'h1f;

   // divided clock: divide by 4, half period 2 cycles
   localparam logic [1:0] DIV4_HALF      = 2'h1;
   localparam logic [7:0] FRAME_LAST     = 8'h07;

   // input pin order in the synchroniser vector
   localparam int PIN_LOCK   = 0;
   localparam int PIN_SREF   = 1;
   localparam int PIN_SETUP  = 2;
   localparam int PIN_HOLD   = 3;
   localparam int PIN_CLKF   = 4;
   localparam int NUM_PINS   = 5;

endpackage

/* rtl/converter_ctrl_irq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_ctrl_irq_regs #(
   parameter int FRAME_W = 8
) (
   // clock, reset, enable
   input  wire logic               CLK_SYS,
   input  wire logic               NRST,
   input  wire logic               CE,
   // apb slave
   input  wire logic               PSEL,
   input  wire logic               PENABLE,
   input  wire logic               PWRITE,
   input  wire logic [11:0]        PADDR,
   input  wire logic [31:0]        PWDATA,
   output logic                    PREADY,
   output logic [31:0]             PRDATA,
   output logic                    PSLVERR,
   // asynchronous status pins
   input  wire logic               PLL_LOCKED,
   input  wire logic               SYSREF,
   input  wire logic               SREF_SETUP_FAIL,
   input  wire logic               SREF_HOLD_FAIL,
   input  wire logic               CLK_FAULT,
   // block outputs
   output logic                    IRQ,
   output logic                    DIVIDED_CLOCK_OUTPUT,
   output logic [FRAME_W-1:0]      FRAME_PHASE,
   output logic                    CAL_THR_EN,
   output logic [7:0]              CAL_THR_A,
   output logic [7:0]              CAL_THR_B,
   output logic [4:0]              DIG_CTRL
);

   // shadow copies written by software
   logic [7:0]          frm_ofs;
   logic [7:0]          div_ratio;
   logic [7:0]          rsvd_f9;
   logic [7:0]          dig_ctrl;
   logic [7:0]          cal_ctrl;
   logic [7:0]          thr_a;
   logic [7:0]          thr_b;
   logic [7:0]          sref_ctrl;
   logic [7:0]          irq_mask;
   logic [7:0]          irq_stat;
   logic                xfer;
   // active copies used by the logic
   logic [7:0]          act_ofs;
   logic                act_ratio;
   // pin synchronisers
   logic [4:0]          s1;
   logic [4:0]          s2;
   logic [4:0]          s3;
   logic [4:0]          pin;
   logic                sref_prev;
   // divider
   logic [1:0]          div_cnt;
   // bus decode
   logic [8:0]          idx;
   logic                wr;
   logic                setup_ph;
   logic                sref_clr_seq;
   logic [7:0]          next_stat;
   logic [7:0]          w8;

   // resting levels of the pins: the lock pin idles high, the rest low;
   // the synchroniser starts there so a reset never fakes an unlock
   localparam logic [4:0] pin_rest = 5'(1 << conv_regs_pkg::PIN_LOCK);

   // true for indices that exist
   function automatic logic mapped(input logic [8:0] i);
      case (i)
         conv_regs_pkg::IDX_SREF_CTRL,
         conv_regs_pkg::IDX_FRM_OFS,
         conv_regs_pkg::IDX_DIV_RATIO,
         conv_regs_pkg::IDX_RSVD_F9,
         conv_regs_pkg::IDX_XFER,
         conv_regs_pkg::IDX_IRQ_STAT,
         conv_regs_pkg::IDX_IRQ_MASK,
         conv_regs_pkg::IDX_DIG_CTRL,
         conv_regs_pkg::IDX_CAL_CTRL,
         conv_regs_pkg::IDX_CAL_THR_A,
         conv_regs_pkg::IDX_CAL_THR_B: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   assign idx = PADDR[10:2];
   assign setup_ph = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   assign w8 = PWDATA[7:0];

   // bit 6 written from one back to zero clears the sysref flags
   // a write of one alone only arms the sequence
   assign sref_clr_seq = wr && (idx == conv_regs_pkg::IDX_SREF_CTRL)
                         && sref_ctrl[conv_regs_pkg::BIT_SREF_CLR]
                         && !w8[conv_regs_pkg::BIT_SREF_CLR];

   // three-stage synchroniser on every pin
   // stage one is read only by stage two
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         s1 <= pin_rest;
         s2 <= pin_rest;
         s3 <= pin_rest;
      end
      else if (CE)
      begin
         s1 <= {CLK_FAULT, SREF_HOLD_FAIL, SREF_SETUP_FAIL, SYSREF, PLL_LOCKED};
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a pin change counts once stages two and three agree
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         pin <= pin_rest;
         sref_prev <= 1'b0;
      end
      else if (CE)
      begin
         for (int i = 0; i < conv_regs_pkg::NUM_PINS; i++)
         begin
            if (s2[i] == s3[i])
               pin[i] <= s3[i];
         end
         sref_prev <= pin[conv_regs_pkg::PIN_SREF];
      end
   end

   // apb handshake: one access cycle, answer registered
   // address bit 11 and the byte lanes are ignored; upper read data stays zero
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         PREADY <= 1'b0;
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else if (CE)
      begin
         PREADY <= setup_ph;
         PSLVERR <= setup_ph && !mapped(idx);
         PRDATA <= 32'h0000_0000;
         if (setup_ph && !PWRITE)
         begin
            case (idx)
               conv_regs_pkg::IDX_SREF_CTRL: PRDATA[7:0] <= sref_ctrl;
               conv_regs_pkg::IDX_FRM_OFS:   PRDATA[7:0] <= frm_ofs;
               conv_regs_pkg::IDX_DIV_RATIO: PRDATA[7:0] <= div_ratio;
               conv_regs_pkg::IDX_RSVD_F9:   PRDATA[7:0] <= rsvd_f9;
               conv_regs_pkg::IDX_XFER:      PRDATA[0] <= xfer;
               conv_regs_pkg::IDX_IRQ_STAT:  PRDATA[7:0] <= irq_stat;
               conv_regs_pkg::IDX_IRQ_MASK:  PRDATA[7:0] <= irq_mask;
               conv_regs_pkg::IDX_DIG_CTRL:  PRDATA[7:0] <= dig_ctrl;
               conv_regs_pkg::IDX_CAL_CTRL:  PRDATA[7:0] <= cal_ctrl;
               conv_regs_pkg::IDX_CAL_THR_A: PRDATA[7:0] <= thr_a;
               conv_regs_pkg::IDX_CAL_THR_B: PRDATA[7:0] <= thr_b;
               default:                      PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software-written shadow registers
   // read-only and unmapped indices fall to the default and change nothing
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         frm_ofs <= conv_regs_pkg::RST_ZERO;
         div_ratio <= conv_regs_pkg::RST_ZERO;
         rsvd_f9 <= conv_regs_pkg::RST_ZERO;
         dig_ctrl <= conv_regs_pkg::RST_ZERO;
         cal_ctrl <= conv_regs_pkg::RST_CAL_CTRL;
         thr_a <= conv_regs_pkg::RST_CAL_THR_A;
         thr_b <= conv_regs_pkg::RST_CAL_THR_B;
         sref_ctrl <= conv_regs_pkg::RST_ZERO;
         irq_mask <= conv_regs_pkg::RST_IRQ_MASK;
      end
      else if (CE && wr)
      begin
         case (idx)
            conv_regs_pkg::IDX_SREF_CTRL: sref_ctrl <= w8;
            conv_regs_pkg::IDX_FRM_OFS:   frm_ofs <= w8;
            conv_regs_pkg::IDX_DIV_RATIO: div_ratio <= w8;
            conv_regs_pkg::IDX_RSVD_F9:   rsvd_f9 <= w8;
            conv_regs_pkg::IDX_IRQ_MASK:  irq_mask <= w8 & conv_regs_pkg::MASK_BITS;
            conv_regs_pkg::IDX_DIG_CTRL:  dig_ctrl <= {3'h0, w8[4:0]};
            conv_regs_pkg::IDX_CAL_CTRL:  cal_ctrl <= w8 & conv_regs_pkg::RST_CAL_CTRL;
            conv_regs_pkg::IDX_CAL_THR_A: thr_a <= w8;
            conv_regs_pkg::IDX_CAL_THR_B: thr_b <= w8;
            default:                      sref_ctrl <= sref_ctrl;
         endcase
      end
   end

   // transfer strobe: set by a write of one, cleared by the copy
   // a new write of one in the copy cycle arms it again, so no request is lost
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         xfer <= 1'b0;
      else if (CE)
      begin
         if (wr && idx == conv_regs_pkg::IDX_XFER && w8[conv_regs_pkg::BIT_XFER])
            xfer <= 1'b1;
         else if (xfer)
            xfer <= 1'b0;
      end
   end

   // shadow to active copy; outputs move together so the
   // analogue side never sees a half-updated set
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         act_ofs <= conv_regs_pkg::RST_ZERO;
         act_ratio <= 1'b0;
         CAL_THR_EN <= conv_regs_pkg::RST_CAL_CTRL[conv_regs_pkg::BIT_CAL_EN];
         CAL_THR_A <= conv_regs_pkg::RST_CAL_THR_A;
         CAL_THR_B <= conv_regs_pkg::RST_CAL_THR_B;
         DIG_CTRL <= 5'h00;
      end
      else if (CE && xfer)
      begin
         act_ofs <= frm_ofs;
         act_ratio <= div_ratio[conv_regs_pkg::BIT_RATIO];
         CAL_THR_EN <= cal_ctrl[conv_regs_pkg::BIT_CAL_EN];
         CAL_THR_A <= thr_a;
         CAL_THR_B <= thr_b;
         DIG_CTRL <= dig_ctrl[4:0] & conv_regs_pkg::DIG_CTRL_BITS;
      end
   end

   // frame phase counter, reloaded on each sysref rising edge;
   // offsets above seven are not valid and still load as written
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         FRAME_PHASE <= '0;
      else if (CE)
      begin
         if (pin[conv_regs_pkg::PIN_SREF] && !sref_prev)
            FRAME_PHASE <= FRAME_W'(act_ofs);
         else if (FRAME_PHASE >= FRAME_W'(conv_regs_pkg::FRAME_LAST))
            FRAME_PHASE <= '0;
         else
            FRAME_PHASE <= FRAME_PHASE + FRAME_W'(1);
      end
   end

   // divide-by-4 clock; ratio one is unsupported and holds the output low
   // leaving the unsupported ratio restarts the count from zero
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
      begin
         div_cnt <= 2'h0;
         DIVIDED_CLOCK_OUTPUT <= 1'b0;
      end
      else if (CE)
      begin
         if (act_ratio)
         begin
            div_cnt <= 2'h0;
            DIVIDED_CLOCK_OUTPUT <= 1'b0;
         end
         else if (div_cnt == conv_regs_pkg::DIV4_HALF)
         begin
            div_cnt <= 2'h0;
            DIVIDED_CLOCK_OUTPUT <= !DIVIDED_CLOCK_OUTPUT;
         end
         else
            div_cnt <= div_cnt + 2'h1;
      end
   end

   // status flags: events set, w1c clears, set wins over clear
   // a pin still at its fault level (lock low, the others high) keeps its flag through any clear
   always_comb
   begin
      next_stat = irq_stat;
      if (wr && idx == conv_regs_pkg::IDX_IRQ_STAT)
         next_stat = next_stat & ~(w8 & conv_regs_pkg::STAT_BITS);
      // clock error survives everything but reset
      next_stat[conv_regs_pkg::BIT_CLKERR] = irq_stat[conv_regs_pkg::BIT_CLKERR];
      if (sref_clr_seq)
      begin
         next_stat[conv_regs_pkg::BIT_HOLD] = 1'b0;
         next_stat[conv_regs_pkg::BIT_SETUP] = 1'b0;
      end
      if (!pin[conv_regs_pkg::PIN_LOCK])
         next_stat[conv_regs_pkg::BIT_PLL] = 1'b1;
      if (pin[conv_regs_pkg::PIN_HOLD])
         next_stat[conv_regs_pkg::BIT_HOLD] = 1'b1;
      if (pin[conv_regs_pkg::PIN_SETUP])
         next_stat[conv_regs_pkg::BIT_SETUP] = 1'b1;
      if (pin[conv_regs_pkg::PIN_CLKF])
         next_stat[conv_regs_pkg::BIT_CLKERR] = 1'b1;
   end

   // status register; a low enable holds every flag
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         irq_stat <= conv_regs_pkg::RST_ZERO;
      else if (CE)
         irq_stat <= next_stat;
   end

   // interrupt line: any flag whose mask bit is zero
   // built from next_stat so the line rises in the same cycle as the flag
   always_ff @(posedge CLK_SYS or negedge NRST)
   begin
      if (!NRST)
         IRQ <= 1'b0;
      else if (CE)
         IRQ <= |(next_stat & ~irq_mask & conv_regs_pkg::STAT_BITS);
   end

endmodule
`default_nettype wire

/* tb/converter_ctrl_irq_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_ctrl_irq_regs_checker #(
   parameter int FRAME_W = 8
) (
   // clock and reset
   input wire logic               CLK_SYS,
   input wire logic               NRST,
   input wire logic               CE,
   // apb
   input wire logic               PSEL,
   input wire logic               PENABLE,
   input wire logic               PWRITE,
   input wire logic [11:0]        PADDR,
   input wire logic [31:0]        PWDATA,
   input wire logic               PREADY,
   input wire logic [31:0]        PRDATA,
   input wire logic               PSLVERR,
   // pins and active outputs
   input wire logic               SYSREF,
   input wire logic               DIVIDED_CLOCK_OUTPUT,
   input wire logic [FRAME_W-1:0] FRAME_PHASE,
   input wire logic               CAL_THR_EN,
   input wire logic [7:0]         CAL_THR_A,
   input wire logic [7:0]         CAL_THR_B,
   input wire logic [4:0]         DIG_CTRL
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   // a low enable freezes the block, so nothing is judged then
   default disable iff (!NRST || !CE);
   // completed write of a one to the transfer strobe
   logic xfer_hit;
   assign xfer_hit = PSEL && PENABLE && PREADY && PWRITE && PWDATA[0]
                     && (PADDR[10:2] == conv_regs_pkg::IDX_XFER);
   // long enough that no sync edge can still be in flight
   sequence sref_quiet;
      !SYSREF [*6];
   endsequence
   // rest of one quarter-rate period after a rising edge
   sequence div_period;
      DIVIDED_CLOCK_OUTPUT ##1 !DIVIDED_CLOCK_OUTPUT [*2] ##1 DIVIDED_CLOCK_OUTPUT;
   endsequence
   pready_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready after setup cycle");
   pready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held longer than one cycle");
   slverr_ready_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
      else $error("error response without ready or with data");
   rdata_upper_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
      else $error("upper read data not zero");
   div_shape_a: assert property ($rose(DIVIDED_CLOCK_OUTPUT) |=> div_period)
      else $error("divided clock not two high two low");
   frame_count_a: assert property (sref_quiet |=>
      FRAME_PHASE == FRAME_W'(($past(FRAME_PHASE) + 1) % 8))
      else $error("phase counter did not step by one modulo eight");
   active_hold_a: assert property ($changed(CAL_THR_A) || $changed(CAL_THR_B)
      || $changed(DIG_CTRL) || $changed(CAL_THR_EN) |-> $past(xfer_hit, 2))
      else $error("active copy changed without transfer");
   stat_bits_a: assert property (PREADY && !PWRITE
      && PADDR[10:2] == conv_regs_pkg::IDX_IRQ_STAT |-> (PRDATA[7:0] & ~conv_regs_pkg::STAT_BITS) == 8'h00)
      else $error("unused status bit reads one");
endmodule
bind converter_ctrl_irq_regs converter_ctrl_irq_regs_checker #(.FRAME_W(FRAME_W)) chk_u (.*);
`default_nettype wire

/* tb/converter_ctrl_irq_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_ctrl_irq_regs_tb;
   // signals named as the ports, so most of the instance binds by name
   logic        CLK_SYS = 1'b0;
   logic        NRST = 1'b0;
   logic        CE = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic        PREADY, PSLVERR, IRQ, DIVIDED_CLOCK_OUTPUT, CAL_THR_EN, er;
   logic [31:0] PRDATA;
   logic [7:0]  FRAME_PHASE, CAL_THR_A, CAL_THR_B, rd;
   logic [4:0]  DIG_CTRL;
   logic [4:0]  pins = 5'h01;
   int          fail_count = 0;
   int          checks_done = 0;
   // 200 MHz
   always #2.5 CLK_SYS = ~CLK_SYS;
   converter_ctrl_irq_regs #(.FRAME_W(8)) dut_u (
      .*,
      .PLL_LOCKED      (pins[conv_regs_pkg::PIN_LOCK]),
      .SYSREF          (pins[conv_regs_pkg::PIN_SREF]),
      .SREF_SETUP_FAIL (pins[conv_regs_pkg::PIN_SETUP]),
      .SREF_HOLD_FAIL  (pins[conv_regs_pkg::PIN_HOLD]),
      .CLK_FAULT       (pins[conv_regs_pkg::PIN_CLKF])
   );
   // case-equal compare, so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge CLK_SYS);
   endtask
   // one apb transfer; ready, read data and error are all taken at the rising edge
   task automatic bus(input logic w, input logic [8:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {1'b0, ix, 2'b00};
      PWDATA <= {24'h0, d};
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         n++;
      end
      while (PREADY !== 1'b1 && n < 20);
      chk(32'(PREADY), 32'h1);
      rd = PRDATA[7:0];
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [8:0] ix, input logic [7:0] d);
      bus(1'b1, ix, d);
   endtask
   task automatic rdc(input logic [8:0] ix, input logic [7:0] e);
      bus(1'b0, ix, 8'h00);
      chk(32'(rd), 32'(e));
   endtask
   task automatic pin(input int k, input logic v);
      @(posedge CLK_SYS);
      pins[k] <= v;
   endtask
   // reset values of the table, active outputs and the divided clock duty
   task automatic t_reset();
      logic [8:0] ix [9];
      logic [7:0] ev [9];
      int         n;
      ix = '{conv_regs_pkg::IDX_FRM_OFS, conv_regs_pkg::IDX_DIV_RATIO, conv_regs_pkg::IDX_XFER,
         conv_regs_pkg::IDX_IRQ_STAT, conv_regs_pkg::IDX_IRQ_MASK, conv_regs_pkg::IDX_DIG_CTRL,
         conv_regs_pkg::IDX_CAL_CTRL, conv_regs_pkg::IDX_CAL_THR_A, conv_regs_pkg::IDX_CAL_THR_B};
      ev = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h10, 8'h3d, 8'h14};
      for (int i = 0; i < 9; i++)
         rdc(ix[i], ev[i]);
      chk(32'({CAL_THR_EN, CAL_THR_A, CAL_THR_B, DIG_CTRL}), 32'h0027a280);
      n = 0;
      repeat (16) @(negedge CLK_SYS) n += int'(DIVIDED_CLOCK_OUTPUT === 1'b1);
      chk(32'(n), 32'h8);
   endtask
   // shadow writes stay hidden until the strobe; unmapped index refused
   task automatic t_shadow();
      wr(conv_regs_pkg::IDX_CAL_THR_A, 8'ha5);
      wr(conv_regs_pkg::IDX_CAL_THR_B, 8'h5a);
      wr(conv_regs_pkg::IDX_CAL_CTRL, 8'h00);
      wr(conv_regs_pkg::IDX_DIG_CTRL, 8'h15);
      rdc(conv_regs_pkg::IDX_CAL_THR_B, 8'h5a);
      wr(conv_regs_pkg::IDX_XFER, 8'h00);
      wt(3);
      chk(32'({CAL_THR_EN, CAL_THR_A}), 32'h13d);
      wr(conv_regs_pkg::IDX_XFER, 8'h01);
      wt(2);
      chk(32'({CAL_THR_EN, CAL_THR_A, CAL_THR_B, DIG_CTRL}), 32'h0014ab55);
      rdc(conv_regs_pkg::IDX_XFER, 8'h00);
      bus(1'b0, 9'h1ff, 8'h00);
      chk(32'({er, rd}), 32'h100);
      wr(conv_regs_pkg::IDX_CAL_CTRL, 8'h10);
      wr(conv_regs_pkg::IDX_XFER, 8'h01);
      wt(2);
      chk(32'(CAL_THR_EN), 32'h1);
   endtask
   // after the sync edge the phase depends only on the offset
   task automatic t_frame();
      logic [7:0] r [2];
      logic [8:0] hold;
      for (int i = 0; i < 2; i++)
      begin
         wr(conv_regs_pkg::IDX_FRM_OFS, 8'h03 + 8'(4 * i));
         wr(conv_regs_pkg::IDX_XFER, 8'h01);
         wt(3 + i);
         pin(conv_regs_pkg::PIN_SREF, 1'b1);
         wt(10);
         r[i] = FRAME_PHASE;
         pin(conv_regs_pkg::PIN_SREF, 1'b0);
         wt(8);
      end
      chk(32'((r[1] - r[0]) & 8'h07), 32'h4);
      // a low enable freezes the counter and the divided clock
      @(posedge CLK_SYS);
      CE <= 1'b0;
      wt(1);
      hold = {DIVIDED_CLOCK_OUTPUT, FRAME_PHASE};
      wt(5);
      chk(32'({DIVIDED_CLOCK_OUTPUT, FRAME_PHASE}), 32'(hold));
      @(posedge CLK_SYS);
      CE <= 1'b1;
   endtask
   // unlock sets status and interrupt; the mask hides only the interrupt
   task automatic t_irq();
      pin(conv_regs_pkg::PIN_LOCK, 1'b0);
      wt(8);
      rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h80);
      chk(32'(IRQ), 32'h1);
      wr(conv_regs_pkg::IDX_IRQ_MASK, 8'hb0);
      wt(2);
      chk(32'(IRQ), 32'h0);
      rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h80);
      pin(conv_regs_pkg::PIN_LOCK, 1'b1);
      wt(8);
      wr(conv_regs_pkg::IDX_IRQ_MASK, 8'h30);
      wr(conv_regs_pkg::IDX_IRQ_STAT, 8'h80);
      rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h00);
      chk(32'(IRQ), 32'h0);
   endtask
   // setup then hold error, each cleared by the set-and-clear sequence
   task automatic t_sref();
      for (int i = 0; i < 2; i++)
      begin
         pin(conv_regs_pkg::PIN_SETUP + i, 1'b1);
         wt(8);
         pin(conv_regs_pkg::PIN_SETUP + i, 1'b0);
         wt(6);
         rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h04 << i);
         chk(32'(IRQ), 32'h1);
         wr(conv_regs_pkg::IDX_SREF_CTRL, 8'h40);
         wr(conv_regs_pkg::IDX_SREF_CTRL, 8'h00);
         rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h00);
      end
   endtask
   // clock fault ignores write-one-clear and goes only with a reset
   task automatic t_clkerr();
      pin(conv_regs_pkg::PIN_CLKF, 1'b1);
      wt(8);
      pin(conv_regs_pkg::PIN_CLKF, 1'b0);
      wt(6);
      wr(conv_regs_pkg::IDX_IRQ_STAT, 8'h01);
      rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h01);
      chk(32'(IRQ), 32'h1);
      wr(conv_regs_pkg::IDX_IRQ_MASK, 8'h31);
      wt(2);
      chk(32'(IRQ), 32'h0);
      @(posedge CLK_SYS);
      NRST <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      NRST <= 1'b1;
      rdc(conv_regs_pkg::IDX_IRQ_STAT, 8'h00);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // reset for two cycles, then the scenarios in turn
   initial
   begin
      repeat (2) @(posedge CLK_SYS);
      NRST <= 1'b1;
      t_reset();
      t_shadow();
      t_frame();
      t_irq();
      t_sref();
      t_clkerr();
      conclude();
   end
   // the run needs well under two thousand cycles
   initial
   begin
      #50000;
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire
